//--- src/usbsc_core.sv
`include "usbsc_map.svh"

module usbsc_core (
   input  wire logic                    clock_i,                   // Clock
   input  wire logic                    rst_n_i,                   // Reset
   input  wire logic                    line_dp_i,                 // D+ pin
   input  wire logic                    line_dm_i,                 // D- pin
   input  wire logic                    hs_activity_i,             // HS seen
   input  wire logic                    hs_disconnect_i,           // HS gone
   input  wire logic                    active_low_disable_in_n_i, // Disable
   input  wire logic [`USBSC_GAIN_W-1:0] gain_select_strap_i,      // Strap
   output logic                         connection_detect_out_o,   // Link up
   output logic                         high_speed_active_out_o,   // HS link
   output logic                         eq_enable_o,               // Comp on
   output logic      [`USBSC_GAIN_W-1:0] eq_gain_o,                // Gain
   output logic                         line_pass_o                // Through
);
   import usbsc_pkg::*;

   localparam logic [`USBSC_CNT_W-1:0] EN_LAST  =
      `USBSC_CNT_W'(`USBSC_T_EN_CYC - 1);
   localparam logic [`USBSC_CNT_W-1:0] DIS_LAST =
      `USBSC_CNT_W'(`USBSC_T_DIS_CYC - 1);
   localparam logic [`USBSC_HQ_W-1:0]  HSQ_LAST =
      `USBSC_HQ_W'(`USBSC_T_HSQ_CYC - 1);

   logic [`USBSC_SY_W-1:0]   sy;
   logic                     dp;
   logic                     dm;
   logic                     act;
   logic                     disc;
   logic                     en;
   logic [`USBSC_GAIN_W-1:0] strap;
   usbsc_core_t              q, d;

   usbsc_sync u_sync (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .async_i ({gain_select_strap_i, active_low_disable_in_n_i,
                 hs_disconnect_i, hs_activity_i, line_dm_i, line_dp_i}),
      .sync_o  (sy)
   );

   assign dp    = sy[`USBSC_SY_DP];
   assign dm    = sy[`USBSC_SY_DM];
   assign act   = sy[`USBSC_SY_ACT];
   assign disc  = sy[`USBSC_SY_DISC];
   assign en    = sy[`USBSC_SY_EN];
   assign strap = sy[`USBSC_SY_GAIN_HI:`USBSC_SY_GAIN_LO];

   // Idle line with the pull-up on D+ means full speed, on D- low speed.
   function automatic logic idle_fs(input logic p, input logic m);
      return p & ~m;
   endfunction : idle_fs

   function automatic logic idle_ls(input logic p, input logic m);
      return ~p & m;
   endfunction : idle_ls

   function automatic logic is_se0(input logic p, input logic m);
      return ~p & ~m;
   endfunction : is_se0

   always_comb begin
      d      = q;
      d.pass = 1'b1;
      unique case (q.st)
         ST_OFF: begin
            d.cnt = '0;
            d.hq  = '0;
            if (en) begin
               d.st = ST_IDLE;
            end
         end
         ST_IDLE: begin
            d.cnt = '0;
            d.hq  = '0;
            if (idle_fs(dp, dm) || idle_ls(dp, dm)) begin
               d.st      = ST_DEB;
               d.cand_ls = idle_ls(dp, dm);
            end
         end
         ST_DEB: begin
            if (q.cand_ls ? idle_ls(dp, dm) : idle_fs(dp, dm)) begin
               if (q.cnt == EN_LAST) begin
                  d.st  = q.cand_ls ? ST_LS : ST_FS;
                  d.cnt = '0;
               end else begin
                  d.cnt = q.cnt + `USBSC_CNT_W'(1);
               end
            end else begin
               d.st = ST_IDLE;
            end
         end
         ST_LS, ST_FS: begin
            // A short SE0 is a reset or end of packet, not a detach.
            if (is_se0(dp, dm) && !act) begin
               if (q.cnt == DIS_LAST) begin
                  d.st = ST_IDLE;
               end else begin
                  d.cnt = q.cnt + `USBSC_CNT_W'(1);
               end
            end else begin
               d.cnt = '0;
            end
            // Only a full speed attach can move up to high speed.
            if (q.st == ST_FS && act) begin
               if (q.hq == HSQ_LAST) begin
                  d.st  = ST_HS;
                  d.cnt = '0;
               end else begin
                  d.hq = q.hq + `USBSC_HQ_W'(1);
               end
            end else begin
               d.hq = '0;
            end
         end
         ST_HS: begin
            if (disc) begin
               d.st = ST_IDLE;
            end
         end
         default: begin
            d.st = ST_OFF;
         end
      endcase

      // Disable overrides every state and arms a fresh strap sample.
      if (!en) begin
         d.st   = ST_OFF;
         d.pend = 1'b1;
      end else if (q.pend) begin
         d.gain = strap;
         d.pend = 1'b0;
      end

      d.link  = (d.st == ST_LS) || (d.st == ST_FS) ||
                (d.st == ST_HS);
      d.hs    = (d.st == ST_HS);
      d.eq_en = (d.st == ST_HS);
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         q         <= '0;
         q.st      <= ST_OFF;
         q.pend    <= 1'b1;
         q.gain    <= `USBSC_GAIN_FLOAT;
         q.pass    <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign connection_detect_out_o = q.link;
   assign high_speed_active_out_o = q.hs;
   assign eq_enable_o             = q.eq_en;
   assign eq_gain_o               = q.gain;
   assign line_pass_o             = q.pass;

   // Checks.
   sequence s_ls_held;
      (q.st == ST_DEB) && q.cand_ls && (q.cnt == EN_LAST) && idle_ls(dp, dm)
      && en;
   endsequence

   sequence s_fs_held;
      (q.st == ST_DEB) && !q.cand_ls && (q.cnt == EN_LAST)
      && idle_fs(dp, dm) && en;
   endsequence

   property p_ls_mode;
      @(posedge clock_i) disable iff (!rst_n_i)
      s_ls_held |=> connection_detect_out_o && !eq_enable_o
                    && !high_speed_active_out_o;
   endproperty
   a_ls_mode: assert property (p_ls_mode)
      else $error("low speed attach did not raise detect alone");

   property p_fs_mode;
      @(posedge clock_i) disable iff (!rst_n_i)
      s_fs_held |=> connection_detect_out_o && !eq_enable_o;
   endproperty
   a_fs_mode: assert property (p_fs_mode)
      else $error("full speed attach did not raise detect");

   property p_hs_mode;
      @(posedge clock_i) disable iff (!rst_n_i)
      $rose(high_speed_active_out_o) |-> connection_detect_out_o
         && eq_enable_o && $past(q.st) == ST_FS && $past(q.hq) == HSQ_LAST;
   endproperty
   a_hs_mode: assert property (p_hs_mode)
      else $error("high speed entry without qualified activity");

   property p_disable;
      @(posedge clock_i) disable iff (!rst_n_i)
      !en |=> !connection_detect_out_o && !high_speed_active_out_o
              && !eq_enable_o;
   endproperty
   a_disable: assert property (p_disable)
      else $error("status or compensation active while disabled");

   property p_pass;
      @(posedge clock_i) disable iff (!rst_n_i)
      line_pass_o;
   endproperty
   a_pass: assert property (p_pass)
      else $error("line pass-through dropped");

   property p_eq_only_hs;
      @(posedge clock_i) disable iff (!rst_n_i)
      eq_enable_o |-> high_speed_active_out_o && q.st == ST_HS;
   endproperty
   a_eq_only_hs: assert property (p_eq_only_hs)
      else $error("compensation on outside high speed");

   property p_gain_hold;
      @(posedge clock_i) disable iff (!rst_n_i)
      en && !q.pend |=> $stable(eq_gain_o);
   endproperty
   a_gain_hold: assert property (p_gain_hold)
      else $error("gain changed without a reset or disable toggle");

   property p_gain_sample;
      @(posedge clock_i) disable iff (!rst_n_i)
      $rose(en) ##1 en |=> eq_gain_o == $past(strap, 2);
   endproperty
   a_gain_sample: assert property (p_gain_sample)
      else $error("strap not re-sampled on enable release");

   property p_no_link;
      @(posedge clock_i) disable iff (!rst_n_i)
      (q.st == ST_IDLE) |-> !connection_detect_out_o
                            && !high_speed_active_out_o;
   endproperty
   a_no_link: assert property (p_no_link)
      else $error("status raised with no connection");

endmodule : usbsc_core

//--- shared/usbsc_map.svh
`ifndef USBSC_MAP_SVH
`define USBSC_MAP_SVH

// Core clock period.
`define USBSC_CLK_NS       8

// Connect qualification (status enable) and disconnect (status disable).
`define USBSC_T_EN_US      20
`define USBSC_T_DIS_US     20
`define USBSC_T_EN_CYC     ((`USBSC_T_EN_US * 1000 + `USBSC_CLK_NS - 1) \
                            / `USBSC_CLK_NS)
`define USBSC_T_DIS_CYC    ((`USBSC_T_DIS_US * 1000 + `USBSC_CLK_NS - 1) \
                            / `USBSC_CLK_NS)

// High speed activity that must persist before compensation is switched on.
`define USBSC_T_HSQ_NS     2500
`define USBSC_T_HSQ_CYC    ((`USBSC_T_HSQ_NS + `USBSC_CLK_NS - 1) \
                            / `USBSC_CLK_NS)

// Supply stable time the board controller honours before release.
`define USBSC_T_STABLE_US  100

// Highest compensated bit rate in high speed mode.
`define USBSC_HS_MBPS      480

// Gain level strap: floating decodes to the top level.
`define USBSC_GAIN_W       2
`define USBSC_GAIN_FLOAT   2'h3

// Synchroniser bit positions.
`define USBSC_SY_W         7
`define USBSC_SY_DP        0
`define USBSC_SY_DM        1
`define USBSC_SY_ACT       2
`define USBSC_SY_DISC      3
`define USBSC_SY_EN        4
`define USBSC_SY_GAIN_LO   5
`define USBSC_SY_GAIN_HI   6

`define USBSC_CNT_W        12
`define USBSC_HQ_W         9

`endif

//--- shared/usbsc_pkg.sv
`include "usbsc_map.svh"

package usbsc_pkg;

   typedef enum logic [2:0] {
      ST_OFF,
      ST_IDLE,
      ST_DEB,
      ST_LS,
      ST_FS,
      ST_HS
   } usbsc_state_t;

   typedef struct packed {
      logic [`USBSC_SY_W-1:0] s1;
      logic [`USBSC_SY_W-1:0] s2;
   } usbsc_sync_t;

   typedef struct packed {
      usbsc_state_t            st;
      logic [`USBSC_CNT_W-1:0] cnt;
      logic [`USBSC_HQ_W-1:0]  hq;
      logic                    cand_ls;
      logic                    pend;
      logic [`USBSC_GAIN_W-1:0] gain;
      logic                    link;
      logic                    hs;
      logic                    eq_en;
      logic                    pass;
   } usbsc_core_t;

endpackage : usbsc_pkg

//--- src/usbsc_sync.sv
`include "usbsc_map.svh"

module usbsc_sync (
   input  wire logic                    clock_i,   // Core clock
   input  wire logic                    rst_n_i,   // Sync reset, low
   input  wire logic [`USBSC_SY_W-1:0]  async_i,   // Pin levels
   output logic      [`USBSC_SY_W-1:0]  sync_o     // Synchronised levels
);
   import usbsc_pkg::*;

   usbsc_sync_t q, d;

   always_comb begin
      d    = q;
      d.s1 = async_i;
      d.s2 = q.s1;
   end

   // Clearing to zero keeps the enable low until both stages hold pin data.
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign sync_o = q.s2;

endmodule : usbsc_sync

//--- verification/usbsc_line_model.sv
module usbsc_line_model (
   input  wire logic [1:0] mode_i,   // 0 none, 1 FS, 2 LS, 3 HS
   input  wire logic       unplug_i, // HS far end removed
   output logic            dp_o,     // D+ level
   output logic            dm_o,     // D- level
   output logic            act_o,    // HS squelch open
   output logic            disc_o    // HS disconnect seen
);
   timeunit 1ns;
   timeprecision 1ps;

   // A high speed link idles near SE0 between packets, so the J level goes.
   always_comb begin
      dp_o   = (mode_i == 2'h1);
      dm_o   = (mode_i == 2'h2);
      act_o  = (mode_i == 2'h3) && !unplug_i;
      disc_o = unplug_i;
   end
endmodule : usbsc_line_model

//--- verification/tb_usbsc_core.sv
`include "usbsc_map.svh"

`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin \
   err_total++; \
   $display("FAIL t=%0t got=%h exp=%h", $time, got, exp); end end

module tb_usbsc_core;
   timeunit 1ns;
   timeprecision 1ps;

   logic                     clock_i;
   logic                     rst_n_i;
   logic                     active_low_disable_in_n;
   logic [`USBSC_GAIN_W-1:0] gain_select_strap;
   logic [1:0]               mode;
   logic                     unplug;
   logic                     dp, dm, act, disc;
   logic                     link_det, hs, eq, pass;
   logic [`USBSC_GAIN_W-1:0] gain;
   int                       err_total = 0;
   int                       tests_run = 0;

   usbsc_line_model usbsc_line_model_inst (
      .mode_i(mode), .unplug_i(unplug), .dp_o(dp), .dm_o(dm),
      .act_o(act), .disc_o(disc));

   usbsc_core usbsc_core_inst (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .line_dp_i(dp),
      .line_dm_i(dm), .hs_activity_i(act), .hs_disconnect_i(disc),
      .active_low_disable_in_n_i(active_low_disable_in_n),
      .gain_select_strap_i(gain_select_strap),
      .connection_detect_out_o(link_det), .high_speed_active_out_o(hs),
      .eq_enable_o(eq), .eq_gain_o(gain), .line_pass_o(pass));

   initial begin
      clock_i = 1'b0;
      forever #4 clock_i = ~clock_i;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask : tick

   task automatic chk3(input logic c, input logic h, input logic e);
      `CHK(link_det, c)
      `CHK(hs, h)
      `CHK(eq, e)
   endtask : chk3

   // Bounded wait on the detect output; debounce or SE0 time is 2500 cycles.
   task automatic wait_link(input logic v);
      int n = 0;
      while (link_det !== v && n < 3000) begin
         tick(1);
         n++;
      end
      `CHK(link_det, v)
   endtask : wait_link

   task automatic stop_test;
      $display("checks=%0d mismatches=%0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : stop_test

   // Supply counts as stable from time zero; disable stays low meanwhile.
   task automatic t_power;
      rst_n_i = 1'b0;
      active_low_disable_in_n = 1'b0;
      gain_select_strap = 2'h1;
      mode = 2'h0;
      unplug = 1'b0;
      tick(3);
      chk3(1'b0, 1'b0, 1'b0);
      `CHK(gain, `USBSC_GAIN_FLOAT)
      `CHK(pass, 1'b1)
      tick(1);
      rst_n_i = 1'b1;
      mode = 2'h1;
      tick(`USBSC_T_STABLE_US * 1000 / `USBSC_CLK_NS);
      chk3(1'b0, 1'b0, 1'b0);
      `CHK(gain, `USBSC_GAIN_FLOAT)
      active_low_disable_in_n = 1'b1;
      tick(5);
      `CHK(gain, 2'h1)
      $display("test power done");
   endtask : t_power

   // A reset in mid-run must take the strap afresh on its release.
   task automatic t_reset;
      gain_select_strap = 2'h0;
      rst_n_i = 1'b0;
      tick(4);
      chk3(1'b0, 1'b0, 1'b0);
      `CHK(gain, `USBSC_GAIN_FLOAT)
      rst_n_i = 1'b1;
      tick(5);
      `CHK(gain, 2'h0)
      $display("test reset done");
   endtask : t_reset

   task automatic t_fs_hs;
      mode = 2'h1;
      wait_link(1'b1);
      chk3(1'b1, 1'b0, 1'b0);
      gain_select_strap = 2'h2;
      mode = 2'h3;
      tick(300);
      chk3(1'b1, 1'b0, 1'b0);
      tick(20);
      chk3(1'b1, 1'b1, 1'b1);
      `CHK(gain, 2'h1)
      unplug = 1'b1;
      tick(5);
      chk3(1'b0, 1'b0, 1'b0);
      mode = 2'h0;
      unplug = 1'b0;
      tick(10);
      $display("test fs_hs done");
   endtask : t_fs_hs

   task automatic t_disable;
      mode = 2'h1;
      wait_link(1'b1);
      active_low_disable_in_n = 1'b0;
      tick(3);
      chk3(1'b0, 1'b0, 1'b0);
      `CHK(pass, 1'b1)
      tick(100);
      chk3(1'b0, 1'b0, 1'b0);
      // The strap changed during the link; only this release picks it up.
      active_low_disable_in_n = 1'b1;
      tick(4);
      `CHK(gain, 2'h2)
      wait_link(1'b1);
      mode = 2'h0;
      wait_link(1'b0);
      chk3(1'b0, 1'b0, 1'b0);
      $display("test disable done");
   endtask : t_disable

   task automatic t_ls;
      mode = 2'h2;
      wait_link(1'b1);
      chk3(1'b1, 1'b0, 1'b0);
      mode = 2'h0;
      wait_link(1'b0);
      $display("test ls done");
   endtask : t_ls

   task automatic t_gain;
      for (int g = 0; g < 4; g++) begin
         gain_select_strap = g[1:0];
         active_low_disable_in_n = 1'b0;
         tick(3);
         active_low_disable_in_n = 1'b1;
         tick(4);
         `CHK(gain, g[1:0])
      end
      $display("test gain done");
   endtask : t_gain

   initial begin
      t_power();
      t_fs_hs();
      t_disable();
      t_ls();
      t_gain();
      t_reset();
      stop_test();
   end

   // The sequence needs about 28000 cycles; this leaves ample margin.
   initial begin
      #400_000;
      err_total++;
      $display("FAIL t=%0t watchdog expired", $time);
      stop_test();
   end
endmodule : tb_usbsc_core
